/* File: hdl/dual_port_block_memory.sv */
// Purpose: synchronous dual-port memory with two independent ports
// Assumes: both ports on core_clk; user keeps ports off a location the other writes
// Notes: port b build is forced to read_write if both ports ask for the same one-way build
`timescale 1ns/1ps
`default_nettype none
`include "dpbm_defs.svh"
module dual_port_block_memory #(
   parameter int DW = `DPBM_DATA_W,
   parameter int AW = `DPBM_ADDR_W,
   parameter int DEPTH = 1 << AW,
   parameter dpbm_pkg::arch_t ARCH = dpbm_pkg::arch_new,
   parameter dpbm_pkg::wmode_t MODE_A = dpbm_pkg::write_first,
   parameter dpbm_pkg::wmode_t MODE_B = dpbm_pkg::write_first,
   parameter dpbm_pkg::cfg_t CFG_A = dpbm_pkg::read_write,
   parameter dpbm_pkg::cfg_t CFG_B = dpbm_pkg::read_write,
   parameter bit HAS_EN_A = 1'b0,
   parameter bit HAS_EN_B = 1'b0,
   parameter bit HAS_HS_A = 1'b0,
   parameter bit HAS_HS_B = 1'b0,
   parameter bit REG_IN_A = 1'b0,
   parameter bit REG_IN_B = 1'b0,
   parameter int PIPE_A = `DPBM_PIPE_OFF,
   parameter int PIPE_B = `DPBM_PIPE_OFF,
   parameter bit HAS_CLR_A = 1'b0,
   parameter bit HAS_CLR_B = 1'b0,
   parameter logic [DW-1:0] INIT_OUT_A = '0,
   parameter logic [DW-1:0] INIT_OUT_B = '0,
   parameter logic [DW-1:0] GLOBAL_INIT = DW'(`DPBM_GLOBAL_INIT),
   parameter bit LOAD_INIT = 1'b0,
   parameter int INIT_RADIX = `DPBM_INIT_RADIX,
   parameter logic [DEPTH*DW-1:0] INIT_VECTOR = '0
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [AW-1:0] addr_a,
   input wire logic [DW-1:0] din_a,
   input wire logic we_a,
   input wire logic en_a,
   input wire logic new_request_a,
   input wire logic output_sync_clear_a,
   output logic accept_ready_a,
   output logic read_valid_a,
   output logic [DW-1:0] dout_a,
   input wire logic [AW-1:0] addr_b,
   input wire logic [DW-1:0] din_b,
   input wire logic we_b,
   input wire logic en_b,
   input wire logic new_request_b,
   input wire logic output_sync_clear_b,
   output logic accept_ready_b,
   output logic read_valid_b,
   output logic [DW-1:0] dout_b
);
   import dpbm_pkg::*;

   // =====================================================
   // effective build per port
   // older variant has no mode choice and a fixed zero clear
   localparam wmode_t EMODE_A = (ARCH == arch_old) ? read_first : MODE_A;
   localparam wmode_t EMODE_B = (ARCH == arch_old) ? read_first : MODE_B;
   localparam logic [DW-1:0] CLR_A = (ARCH == arch_old) ? DW'(`DPBM_CLEAR_OLD) : INIT_OUT_A;
   localparam logic [DW-1:0] CLR_B = (ARCH == arch_old) ? DW'(`DPBM_CLEAR_OLD) : INIT_OUT_B;
   // two identical one-way ports would leave the array unusable
   localparam cfg_t ECFG_B = (CFG_A == CFG_B && CFG_A != read_write) ? read_write : CFG_B;

   // =====================================================
   // storage
   typedef logic [DW-1:0] word_arr_t [DEPTH];
   // contents set by the initializer so the write process stays the only driver
   // radix only shapes how values are written; each word is already below 2**DW
   function automatic word_arr_t init_words();
      word_arr_t w;
      for (int i = 0; i < DEPTH; i++) begin
         w[i] = LOAD_INIT ? INIT_VECTOR[i*DW +: DW] : GLOBAL_INIT;
      end
      return w;
   endfunction
   word_arr_t mem = init_words();
   logic wr_en [2];
   logic [AW-1:0] wr_addr [2];
   logic [DW-1:0] wr_data [2];

   // both ports write freely; same-location overlap is the user's to avoid
   always_ff @(posedge core_clk) begin
      for (int p = 0; p < 2; p++) begin
         if (wr_en[p]) begin
            mem[wr_addr[p]] <= wr_data[p];
         end
      end
   end

   // =====================================================
   // port a
   port_if #(.AW(AW), .DW(DW)) pa ();

   port_front #(.AW(AW), .DW(DW), .REG_IN(REG_IN_A), .HAS_EN(HAS_EN_A), .HAS_HS(HAS_HS_A)) front_a (
      .core_clk(core_clk),
      .rst(rst),
      .addr(addr_a),
      .din(din_a),
      .we(we_a && CFG_A != read_only),
      .en(en_a),
      .new_request(new_request_a),
      .accept_ready(accept_ready_a),
      .pif(pa.front)
   );

   assign wr_en[0] = pa.we;
   assign wr_addr[0] = pa.addr;
   assign wr_data[0] = pa.din;
   // array read is sampled by the back end register, giving a synchronous read
   assign pa.rword = (pa.we && EMODE_A == write_first) ? pa.din : mem[pa.addr];
   assign pa.load = pa.act && CFG_A != write_only && !(pa.we && EMODE_A == no_change);

   port_back #(.DW(DW), .PIPE(PIPE_A), .HAS_CLR(HAS_CLR_A), .HAS_HS(HAS_HS_A), .CLR_VAL(CLR_A)) back_a (
      .core_clk(core_clk),
      .rst(rst),
      .output_sync_clear(output_sync_clear_a),
      .pif(pa.back),
      .dout(dout_a),
      .read_valid(read_valid_a)
   );

   // =====================================================
   // port b
   port_if #(.AW(AW), .DW(DW)) pb ();

   port_front #(.AW(AW), .DW(DW), .REG_IN(REG_IN_B), .HAS_EN(HAS_EN_B), .HAS_HS(HAS_HS_B)) front_b (
      .core_clk(core_clk),
      .rst(rst),
      .addr(addr_b),
      .din(din_b),
      .we(we_b && ECFG_B != read_only),
      .en(en_b),
      .new_request(new_request_b),
      .accept_ready(accept_ready_b),
      .pif(pb.front)
   );

   assign wr_en[1] = pb.we;
   assign wr_addr[1] = pb.addr;
   assign wr_data[1] = pb.din;
   assign pb.rword = (pb.we && EMODE_B == write_first) ? pb.din : mem[pb.addr];
   assign pb.load = pb.act && ECFG_B != write_only && !(pb.we && EMODE_B == no_change);

   port_back #(.DW(DW), .PIPE(PIPE_B), .HAS_CLR(HAS_CLR_B), .HAS_HS(HAS_HS_B), .CLR_VAL(CLR_B)) back_b (
      .core_clk(core_clk),
      .rst(rst),
      .output_sync_clear(output_sync_clear_b),
      .pif(pb.back),
      .dout(dout_b),
      .read_valid(read_valid_b)
   );
   // with REG_IN and PIPE both set the written word lands on the third edge
   // input reg, core reg, pipe reg in series
endmodule
`default_nettype wire

/* File: hdl/dpbm_defs.svh */
// Purpose: shared constants of the dual-port block memory
// Assumes: included by bare name
// Notes: definitions only
`ifndef DPBM_DEFS_SVH
`define DPBM_DEFS_SVH
// =====================================================
// sizes and init
`define DPBM_DATA_W 16
`define DPBM_ADDR_W 8
`define DPBM_GLOBAL_INIT 0
`define DPBM_INIT_RADIX 16
`define DPBM_CLEAR_OLD 0
// =====================================================
// pipeline
`define DPBM_PIPE_OFF 0
`define DPBM_PIPE_ON 1
`endif

/* File: hdl/dpbm_pkg.sv */
// Purpose: types of the dual-port block memory
// Assumes: nothing
// Notes: one-hot codes
package dpbm_pkg;
   // =====================================================
   // write behaviour of a port's read data during a write
   typedef enum logic [2:0] {
      write_first = 3'b001,
      read_first = 3'b010,
      no_change = 3'b100
   } wmode_t;
   // =====================================================
   // port direction build
   typedef enum logic [2:0] {
      read_write = 3'b001,
      write_only = 3'b010,
      read_only = 3'b100
   } cfg_t;
   // =====================================================
   // architecture variant
   typedef enum logic [1:0] {
      arch_new = 2'b01,
      arch_old = 2'b10
   } arch_t;
endpackage

/* File: hdl/port_if.sv */
// Purpose: signals between a port's front, the array and its back end
// Assumes: single clock
// Notes: none
`timescale 1ns/1ps
`default_nettype none
interface port_if #(parameter int AW = 8, parameter int DW = 16);
   logic [AW-1:0] addr;
   logic [DW-1:0] din;
   logic we;
   logic act;
   logic [DW-1:0] rword;
   logic load;
   modport front (output addr, output din, output we, output act);
   modport core (input addr, input din, input we, input act, output rword, output load);
   modport back (input rword, input load);
endinterface
`default_nettype wire

/* File: hdl/port_front.sv */
// Purpose: input stage of one memory port
// Assumes: inputs come from logic on core_clk
// Notes: optional input registers, activate and handshake gating
`timescale 1ns/1ps
`default_nettype none
module port_front #(
   parameter int AW = 8,
   parameter int DW = 16,
   parameter bit REG_IN = 1'b0,
   parameter bit HAS_EN = 1'b0,
   parameter bit HAS_HS = 1'b0
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] din,
   input wire logic we,
   input wire logic en,
   input wire logic new_request,
   output logic accept_ready,
   port_if.front pif
);
   // =====================================================
   // access qualification
   logic act_c;
   logic [AW-1:0] addr_q, addr_d;
   logic [DW-1:0] din_q, din_d;
   logic we_q, we_d, act_q, act_d;

   // absent pins count as always asserted
   assign act_c = (HAS_EN ? en : 1'b1) & (HAS_HS ? new_request : 1'b1);
   // the array never stalls, so ready follows activate when the handshake is built, and is tied low without it
   assign accept_ready = HAS_HS ? (HAS_EN ? en : 1'b1) : 1'b0;

   // =====================================================
   // input registers
   always_comb begin
      addr_d = addr;
      din_d = din;
      we_d = we & act_c;
      act_d = act_c;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         addr_q <= '0;
         din_q <= '0;
         we_q <= 1'b0;
         act_q <= 1'b0;
      end else begin
         addr_q <= addr_d;
         din_q <= din_d;
         we_q <= we_d;
         act_q <= act_d;
      end
   end

   // one extra edge of latency when registered
   assign pif.addr = REG_IN ? addr_q : addr_d;
   assign pif.din = REG_IN ? din_q : din_d;
   assign pif.we = REG_IN ? we_q : we_d;
   assign pif.act = REG_IN ? act_q : act_d;
endmodule
`default_nettype wire

/* File: hdl/port_back.sv */
// Purpose: output stage of one memory port
// Assumes: load and rword come from the array on core_clk
// Notes: core output register, optional pipe stage, sync clear
`timescale 1ns/1ps
`default_nettype none
`include "dpbm_defs.svh"
module port_back #(
   parameter int DW = 16,
   parameter int PIPE = 0,
   parameter bit HAS_CLR = 1'b0,
   parameter bit HAS_HS = 1'b0,
   parameter logic [DW-1:0] CLR_VAL = '0
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic output_sync_clear,
   port_if.back pif,
   output logic [DW-1:0] dout,
   output logic read_valid
);
   // =====================================================
   // output registers
   logic [DW-1:0] core_q, core_d, pipe_q, pipe_d;
   logic v1_q, v1_d, v2_q, v2_d;
   logic clr;

   assign clr = HAS_CLR & output_sync_clear;

   always_comb begin
      core_d = core_q;
      v1_d = pif.load;
      if (clr) begin
         core_d = CLR_VAL;
         v1_d = 1'b0;
      end else if (pif.load) begin
         core_d = pif.rword;
      end
      // pipe stage copies a held word, so holds stay held
      pipe_d = clr ? CLR_VAL : core_q;
      v2_d = clr ? 1'b0 : v1_q;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         core_q <= '0;
         pipe_q <= '0;
         v1_q <= 1'b0;
         v2_q <= 1'b0;
      end else begin
         core_q <= core_d;
         pipe_q <= pipe_d;
         v1_q <= v1_d;
         v2_q <= v2_d;
      end
   end

   assign dout = (PIPE == `DPBM_PIPE_ON) ? pipe_q : core_q;
   assign read_valid = HAS_HS & ((PIPE == `DPBM_PIPE_ON) ? v2_q : v1_q);
endmodule
`default_nettype wire

/* File: testbench/dpbm_checker.sv */
// Purpose: port checks of the dual-port memory
// Assumes: port a with input regs and pipe, port b plain
// Notes: clear values match the bench build
`timescale 1ns/1ps
`default_nettype none
module dpbm_checker (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic en_a,
   input wire logic new_request_a,
   input wire logic output_sync_clear_a,
   input wire logic accept_ready_a,
   input wire logic read_valid_a,
   input wire logic [15:0] dout_a,
   input wire logic en_b,
   input wire logic new_request_b,
   input wire logic output_sync_clear_b,
   input wire logic accept_ready_b,
   input wire logic read_valid_b,
   input wire logic [15:0] dout_b
);
   // ====
   // port relations
   wire logic req_a = en_a & new_request_a;
   wire logic req_b = en_b & new_request_b;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   lat_a_a: assert property (req_a ##1 (!output_sync_clear_a)[*3] |-> read_valid_a)
      else $error("port a answer late");
   cause_a_a: assert property (read_valid_a |-> $past(req_a, 3))
      else $error("port a valid without request");
   lat_b_a: assert property (req_b && !output_sync_clear_b |=> read_valid_b)
      else $error("port b answer late");
   cause_b_a: assert property (read_valid_b |-> $past(req_b))
      else $error("port b valid without request");
   hold_b_a: assert property (!req_b && !output_sync_clear_b |=> $stable(dout_b))
      else $error("port b data moved while idle");
   hold_a_a: assert property (!$stable(dout_a) |-> read_valid_a || $past(output_sync_clear_a))
      else $error("port a data moved without cause");
   clr_a_a: assert property (output_sync_clear_a |=> dout_a == 16'h00a5)
      else $error("port a clear value wrong");
   clr_b_a: assert property (output_sync_clear_b |=> dout_b == 16'h005a && !read_valid_b)
      else $error("port b clear value wrong");
   rdy_a_a: assert property (accept_ready_a == en_a)
      else $error("port a ready wrong");
   rdy_b_a: assert property (accept_ready_b == en_b)
      else $error("port b ready wrong");
endmodule
`default_nettype wire

/* File: testbench/user_port.sv */
// Purpose: user logic model driving one memory port
// Assumes: requests change just after a rising edge
// Notes: released address and data show inverted values, never stale ones; controls drop to zero
`timescale 1ns/1ps
`default_nettype none
module user_port (
   input wire logic core_clk,
   output logic [7:0] addr,
   output logic [15:0] din,
   output logic we,
   output logic en,
   output logic new_request,
   output logic output_sync_clear
);
   // ====
   // request drive
   initial begin
      {addr, din, we, en, new_request, output_sync_clear} = '0;
   end
   task automatic drive(input logic [7:0] a, input logic [15:0] d, input logic w, input logic e,
                        input logic n, input logic c);
      @(posedge core_clk);
      addr <= a;
      din <= d;
      we <= w;
      en <= e;
      new_request <= n;
      output_sync_clear <= c;
   endtask
   // released: invert so a stale value cannot pass for a good one
   task automatic idle();
      drive(~addr, ~din, 1'b0, 1'b0, 1'b0, 1'b0);
   endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Purpose: self-checking bench of the dual-port memory
// Assumes: port a write-first with both stages, port b read-first plain
// Notes: no_change and old variant are not built here
`timescale 1ns/1ps
`default_nettype none
bind dual_port_block_memory dpbm_checker chk (.core_clk(core_clk), .rst(rst), .en_a(en_a),
   .new_request_a(new_request_a), .output_sync_clear_a(output_sync_clear_a), .accept_ready_a(accept_ready_a),
   .read_valid_a(read_valid_a), .dout_a(dout_a), .en_b(en_b), .new_request_b(new_request_b),
   .output_sync_clear_b(output_sync_clear_b), .accept_ready_b(accept_ready_b), .read_valid_b(read_valid_b),
   .dout_b(dout_b));
module testbench;
   import dpbm_pkg::*;
   // build of the unit; expectations below use the same named values
   localparam bit FEAT_ON = 1'b1;
   localparam int PIPE_ONE = 1;
   localparam logic [15:0] CLR_VAL_A = 16'h00a5;
   localparam logic [15:0] CLR_VAL_B = 16'h005a;
   localparam logic [15:0] INIT_WORD = 16'h1234;
   // ====
   // build and clock
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr_a, addr_b;
   logic [15:0] din_a, din_b, dout_a, dout_b;
   logic we_a, we_b, en_a, en_b, nr_a, nr_b, clr_a, clr_b, rdy_a, rdy_b, read_valid_a, read_valid_b;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   always #50 core_clk = ~core_clk;
   user_port pa (.core_clk(core_clk), .addr(addr_a), .din(din_a), .we(we_a), .en(en_a),
      .new_request(nr_a), .output_sync_clear(clr_a));
   user_port pb (.core_clk(core_clk), .addr(addr_b), .din(din_b), .we(we_b), .en(en_b),
      .new_request(nr_b), .output_sync_clear(clr_b));
   dual_port_block_memory #(.MODE_A(write_first), .MODE_B(read_first), .HAS_EN_A(FEAT_ON), .HAS_EN_B(FEAT_ON),
      .HAS_HS_A(FEAT_ON), .HAS_HS_B(FEAT_ON), .REG_IN_A(FEAT_ON), .PIPE_A(PIPE_ONE), .HAS_CLR_A(FEAT_ON),
      .HAS_CLR_B(FEAT_ON), .INIT_OUT_A(CLR_VAL_A), .INIT_OUT_B(CLR_VAL_B), .GLOBAL_INIT(INIT_WORD)) uut (
      .core_clk(core_clk), .rst(rst), .addr_a(addr_a), .din_a(din_a), .we_a(we_a), .en_a(en_a),
      .new_request_a(nr_a), .output_sync_clear_a(clr_a), .accept_ready_a(rdy_a), .read_valid_a(read_valid_a),
      .dout_a(dout_a), .addr_b(addr_b), .din_b(din_b), .we_b(we_b), .en_b(en_b), .new_request_b(nr_b),
      .output_sync_clear_b(clr_b), .accept_ready_b(rdy_b), .read_valid_b(read_valid_b), .dout_b(dout_b));
   // ====
   // tasks
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic op_b(input logic [7:0] a, input logic [15:0] d, input logic w, input logic e);
      pb.drive(a, d, w, e, 1'b1, 1'b0);
      pb.idle();
      #1;
   endtask
   // two extra edges: input register, then pipe register
   task automatic op_a(input logic [7:0] a, input logic [15:0] d, input logic w, input logic e);
      pa.drive(a, d, w, e, 1'b1, 1'b0);
      pa.idle();
      repeat (2) @(posedge core_clk);
      #1;
   endtask
   task automatic tally_and_finish();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 1000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   // ====
   // tests
   initial begin
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      op_b(8'h10, 16'h0000, 1'b0, 1'b1);
      chk_word(dout_b, INIT_WORD);
      chk_bit(read_valid_b, 1'b1);
      op_b(8'h10, 16'hbeef, 1'b1, 1'b1);
      chk_word(dout_b, INIT_WORD);
      op_b(8'h10, 16'h0000, 1'b0, 1'b1);
      chk_word(dout_b, 16'hbeef);
      $display("test 1 done");
      op_a(8'h20, 16'hc0de, 1'b1, 1'b1);
      chk_word(dout_a, 16'hc0de);
      chk_bit(read_valid_a, 1'b1);
      // both read one word, neither writes it
      fork
         begin
            op_b(8'h10, 16'h0000, 1'b0, 1'b1);
            chk_word(dout_b, 16'hbeef);
         end
         begin
            op_a(8'h10, 16'h0000, 1'b0, 1'b1);
            chk_word(dout_a, 16'hbeef);
         end
      join
      $display("test 2 done");
      op_a(8'h20, 16'h0bad, 1'b1, 1'b0);
      chk_word(dout_a, 16'hbeef);
      chk_bit(read_valid_a, 1'b0);
      op_a(8'h20, 16'h0000, 1'b0, 1'b1);
      chk_word(dout_a, 16'hc0de);
      $display("test 3 done");
      for (int i = 0; i < 4; i++) begin
         pb.drive(8'(8'h30 + i), 16'(16'h0100 + i), 1'b1, 1'b1, 1'b1, 1'b0);
      end
      for (int i = 0; i < 5; i++) begin
         if (i < 4) pb.drive(8'(8'h30 + i), 16'h0000, 1'b0, 1'b1, 1'b1, 1'b0);
         else pb.idle();
         #1;
         if (i > 0) chk_word(dout_b, 16'(16'h00ff + i));
      end
      $display("test 4 done");
      pb.drive(8'h10, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b1);
      pb.idle();
      #1;
      chk_word(dout_b, CLR_VAL_B);
      chk_bit(read_valid_b, 1'b0);
      pa.drive(8'h10, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b1);
      pa.idle();
      #1;
      chk_word(dout_a, CLR_VAL_A);
      $display("test 5 done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
